// [logic/dgp_top.sv]
// Channel front end: gain, pilot insertion and power meter
`timescale 1ns/1ps
`include "dgp_map.svh"
module dgp_top (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        in_valid_i,
   output logic             in_ready_o,
   input  wire logic [17:0] in_i_i,
   input  wire logic [17:0] in_q_i,
   input  wire logic        in_sig_b_i,
   output logic             out_valid_o,
   input  wire logic        out_ready_i,
   output logic [17:0]      out_i_o,
   output logic [17:0]      out_q_o,
   output logic             out_sig_b_o,
   input  wire logic        mode_ab_i,
   input  wire logic [7:0]  sync_i,
   input  wire logic [15:0] gain_a_i,
   input  wire logic [15:0] gain_b_i,
   input  wire logic [2:0]  gain_sync_sel_i,
   input  wire logic [15:0] pilot_psc_lo_i,
   input  wire logic [1:0]  pilot_psc_hi_i,
   input  wire logic        pilot_div_i,
   input  wire logic [15:0] pilot_delay_i,
   input  wire logic [15:0] pilot_gain0_i,
   input  wire logic [15:0] pilot_gain1_i,
   input  wire logic [2:0]  pilot_sync_sel_i,
   input  wire logic [12:0] pm_integ_i,
   input  wire logic [6:0]  pm_delay_i,
   input  wire logic [8:0]  pm_interval_i,
   input  wire logic [2:0]  pm_sync_sel_i,
   input  wire logic        pm_sync_dis_i,
   output logic [15:0]      pm_res_a_lo_o,
   output logic [15:0]      pm_res_a_hi_o,
   output logic [15:0]      pm_res_b_lo_o,
   output logic [15:0]      pm_res_b_hi_o,
   output logic             pm_ready_o
);
   dgp_strm_if #(.W(`DGP_FW)) fw ();
   dgp_strm_if #(.W(`DGP_FW)) fr ();

   logic                  gsync, psync, msync, take, chip, is_b;
   logic [15:0]           gain_a_q, gain_a_d, gain_b_q, gain_b_d, gsel;
   logic [17:0]           x_q, x_d, y_q, y_d;
   logic [15:0]           pdly_q, pdly_d, chip_q, chip_d, chip_ofs;
   logic                  pon_q, pon_d, pact, bit_i, bit_q, neg;
   logic signed [16:0]    g0, g1, pil_i, pil_q;
   dgp_pkg::dgp_smp_t     sy_i, sy_q;
   dgp_pkg::dgp_pm_state_t pm_q, pm_d;
   logic [7:0]            dcnt_q, dcnt_d;
   logic [14:0]           icnt_q, icnt_d, ivl_q, ivl_d, ilast, vlast;
   logic [49:0]           acc_a_q, acc_a_d, acc_b_q, acc_b_d;
   logic [31:0]           res_a_q, res_a_d, res_b_q, res_b_d;
   logic                  rdy_q, rdy_d, last, wrap;
   logic [36:0]           pw, pwi;
   logic signed [35:0]    sq_i, sq_q;

   // Sync selection
   assign gsync = sync_i[gain_sync_sel_i];
   assign psync = sync_i[pilot_sync_sel_i];
   assign msync = sync_i[pm_sync_sel_i] && !pm_sync_dis_i;

   // A sample counts as a chip; in two-channel mode the B sample closes the pair
   assign take = in_valid_i && fw.ready;
   assign is_b = mode_ab_i && in_sig_b_i;
   assign chip = take && (!mode_ab_i || in_sig_b_i);

   // Gain: ports stage the words, a sync moves them into the active copies
   always_comb
   begin
      gain_a_d = gsync ? gain_a_i : gain_a_q;
      gain_b_d = gsync ? gain_b_i : gain_b_q;
      gsel     = is_b ? gain_b_q : gain_a_q;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         gain_a_q <= '0;
         gain_b_q <= '0;
      end
      else
      begin
         gain_a_q <= gain_a_d;
         gain_b_q <= gain_b_d;
      end
   end

   // Pilot generator
   assign pact     = pon_q && (pdly_q == '0);
   assign bit_i    = ^(x_q & `DGP_X_I) ^ ^(y_q & `DGP_Y_I);
   assign bit_q    = ^(x_q & `DGP_X_Q) ^ ^(y_q & `DGP_Y_Q);
   assign chip_ofs = chip_q + `DGP_DIV_OFS;
   assign neg      = pilot_div_i && chip_ofs[`DGP_DIV_BIT];
   assign g0       = {pilot_gain0_i[15], pilot_gain0_i};
   assign g1       = {pilot_gain1_i[15], pilot_gain1_i};

   always_comb
   begin
      // Two-channel data never carries pilot, even if the gains were left set
      if (!pact || mode_ab_i)
      begin
         pil_i = '0;
         pil_q = '0;
      end
      else
      begin
         pil_i = (bit_i ^ neg) ? -g0 : g0;
         pil_q = (bit_q ^ neg) ? -g1 : g1;
      end
   end

   always_comb
   begin
      x_d    = x_q;
      y_d    = y_q;
      pdly_d = pdly_q;
      pon_d  = pon_q;
      chip_d = chip_q;
      if (psync)
      begin
         x_d    = {pilot_psc_hi_i, pilot_psc_lo_i};
         y_d    = `DGP_LFSR_ONES;
         pdly_d = pilot_delay_i;
         pon_d  = 1'b1;
         chip_d = '0;
      end
      else if (chip && pon_q)
      begin
         if (pdly_q != '0)
            pdly_d = pdly_q - 1'b1;
         else
         begin
            x_d    = {^(x_q & `DGP_X_FB), x_q[17:1]};
            y_d    = {^(y_q & `DGP_Y_FB), y_q[17:1]};
            chip_d = (chip_q == `DGP_FRAME_LAST) ? '0 : chip_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         x_q    <= '0;
         y_q    <= `DGP_LFSR_ONES;
         pdly_q <= '0;
         pon_q  <= 1'b0;
         chip_q <= '0;
      end
      else
      begin
         x_q    <= x_d;
         y_q    <= y_d;
         pdly_q <= pdly_d;
         pon_q  <= pon_d;
         chip_q <= chip_d;
      end
   end

   // Gain, pilot sum and clipping per rail
   dgp_gain_sat u_sat_i (
      .smp_i  ($signed(in_i_i)),
      .gain_i (gsel),
      .add_i  (pil_i),
      .y_o    (sy_i)
   );

   dgp_gain_sat u_sat_q (
      .smp_i  ($signed(in_q_i)),
      .gain_i (gsel),
      .add_i  (pil_q),
      .y_o    (sy_q)
   );

   // Downstream filter may stall; back-pressure reaches the source
   assign fw.valid   = in_valid_i;
   assign fw.data    = {in_sig_b_i, sy_q, sy_i};
   assign in_ready_o = fw.ready;

   dgp_fifo #(.W(`DGP_FW), .D(`DGP_FIFO_D)) u_fifo (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .wr       (fw),
      .rd       (fr)
   );

   assign out_valid_o = fr.valid;
   assign fr.ready    = out_ready_i;
   assign out_i_o     = fr.data[17:0];
   assign out_q_o     = fr.data[35:18];
   assign out_sig_b_o = fr.data[36];

   // Power meter, fed with the data that enters the pulse-shaping filter
   // Full-width squares: a self-sized product would keep only 18 bits
   assign sq_i  = sy_i * sy_i;
   assign sq_q  = sy_q * sy_q;
   assign pwi   = {1'b0, sq_i};
   assign pw    = pwi + {1'b0, sq_q};
   assign ilast = {pm_integ_i, 2'b00};
   assign vlast = {pm_interval_i, `DGP_IVL_SUB};
   assign last  = (icnt_q == ilast);
   assign wrap  = (ivl_q == vlast);

   always_comb
   begin
      pm_d    = pm_q;
      dcnt_d  = dcnt_q;
      icnt_d  = icnt_q;
      ivl_d   = ivl_q;
      acc_a_d = acc_a_q;
      acc_b_d = acc_b_q;
      res_a_d = res_a_q;
      res_b_d = res_b_q;
      rdy_d   = 1'b0;
      if (msync)
      begin
         pm_d    = dgp_pkg::PM_DELAY;
         dcnt_d  = `DGP_PM_PRE + {1'b0, pm_delay_i};
         icnt_d  = '0;
         ivl_d   = '0;
         acc_a_d = '0;
         acc_b_d = '0;
      end
      else
      begin
         // The A half of a pair arrives before the B chip that ends it
         if (take && mode_ab_i && !in_sig_b_i && pm_q == dgp_pkg::PM_INTEG)
            acc_a_d = acc_a_q + {13'h0, (last ? pwi : pw)};
         if (chip)
         begin
            case (pm_q)
               dgp_pkg::PM_DELAY:
               begin
                  dcnt_d = dcnt_q - 1'b1;
                  if (dcnt_q == 8'h01)
                     pm_d = dgp_pkg::PM_INTEG;
               end
               dgp_pkg::PM_INTEG:
               begin
                  if (mode_ab_i)
                     acc_b_d = acc_b_q + {13'h0, pw};
                  else
                     acc_a_d = acc_a_q + {13'h0, pw};
                  icnt_d = icnt_q + 1'b1;
                  ivl_d  = ivl_q + 1'b1;
                  if (last)
                  begin
                     // Unread results are simply replaced
                     res_a_d = acc_a_d[`DGP_ACC_TOP:`DGP_ACC_BOT];
                     res_b_d = acc_b_d[`DGP_ACC_TOP:`DGP_ACC_BOT];
                     rdy_d   = 1'b1;
                     pm_d    = dgp_pkg::PM_WAIT;
                  end
               end
               dgp_pkg::PM_WAIT:
                  ivl_d = ivl_q + 1'b1;
               default:
                  pm_d = pm_q;
            endcase
            if ((pm_q == dgp_pkg::PM_INTEG || pm_q == dgp_pkg::PM_WAIT) && wrap)
            begin
               pm_d    = dgp_pkg::PM_INTEG;
               icnt_d  = '0;
               ivl_d   = '0;
               acc_a_d = '0;
               acc_b_d = '0;
            end
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         pm_q    <= dgp_pkg::PM_IDLE;
         dcnt_q  <= '0;
         icnt_q  <= '0;
         ivl_q   <= '0;
         acc_a_q <= '0;
         acc_b_q <= '0;
         res_a_q <= '0;
         res_b_q <= '0;
         rdy_q   <= 1'b0;
      end
      else
      begin
         pm_q    <= pm_d;
         dcnt_q  <= dcnt_d;
         icnt_q  <= icnt_d;
         ivl_q   <= ivl_d;
         acc_a_q <= acc_a_d;
         acc_b_q <= acc_b_d;
         res_a_q <= res_a_d;
         res_b_q <= res_b_d;
         rdy_q   <= rdy_d;
      end
   end

   assign pm_res_a_lo_o = res_a_q[`DGP_HALF-1:0];
   assign pm_res_a_hi_o = res_a_q[31:`DGP_HALF];
   assign pm_res_b_lo_o = res_b_q[`DGP_HALF-1:0];
   assign pm_res_b_hi_o = res_b_q[31:`DGP_HALF];
   assign pm_ready_o    = rdy_q;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_gain_xfer: assert property ($changed(gain_a_q) |-> $past(gsync))
      else $error("gain A changed without sync");
   a_gain_b_sel: assert property (is_b |-> gsel == gain_b_q)
      else $error("B sample not using B gain");
   a_pilot_ab_off: assert property (mode_ab_i |-> pil_i == '0 && pil_q == '0)
      else $error("pilot added in two-channel mode");
   a_pilot_zero: assert property (pilot_gain0_i == '0 |-> pil_i == '0)
      else $error("zero gain still adds pilot");
   a_lfsr_load: assert property (psync |=> y_q == `DGP_LFSR_ONES
                                 && x_q == {$past(pilot_psc_hi_i), $past(pilot_psc_lo_i)})
      else $error("pilot registers not loaded on sync");
   a_pilot_delay: assert property (pdly_q != '0 |-> pil_i == '0 ##1 ($stable(x_q) || $past(psync)))
      else $error("pilot running during start delay");
   a_main_sign: assert property (!pilot_div_i |-> !neg)
      else $error("main pilot sign toggled");
   a_div_head: assert property (pilot_div_i && chip_q < `DGP_DIV_OFS |-> !neg)
      else $error("diversity pilot negative in first chips");
   a_div_toggle: assert property (pilot_div_i && chip_q >= `DGP_DIV_OFS && chip_q[15:`DGP_DIV_BIT] == '0 |-> neg)
      else $error("diversity pilot not negated after first chips");
   a_pm_sync_clr: assert property (msync |=> pm_q == dgp_pkg::PM_DELAY && icnt_q == '0
                                   && ivl_q == '0 && acc_a_q == '0)
      else $error("meter sync did not clear counters");
   a_pm_ready_one: assert property (rdy_q |=> !rdy_q ##1 !rdy_q)
      else $error("ready flag not a single pulse");
   a_pm_result: assert property (rdy_q |-> $past(pm_q) == dgp_pkg::PM_INTEG && $past(chip)
                                 && $past(last) && !$past(msync))
      else $error("result not taken at window end");
   a_pm_ab_a: assert property (take && mode_ab_i && !in_sig_b_i && pm_q == dgp_pkg::PM_INTEG && !msync
                               |=> acc_b_q == $past(acc_b_q))
      else $error("A sample changed the B accumulator");
   a_pm_restart: assert property (chip && wrap && pm_q == dgp_pkg::PM_WAIT && !msync
                                  |=> pm_q == dgp_pkg::PM_INTEG && icnt_q == '0)
      else $error("interval end did not restart integration");
endmodule

// [logic/dgp_map.svh]
// Constants for the gain, pilot and power meter channel front end
`ifndef DGP_MAP_SVH
`define DGP_MAP_SVH
`define DGP_GAIN_FRAC   13
`define DGP_SAT_HI      36'sh0_0001_ffff
`define DGP_SAT_LO      36'shf_fffe_0000
`define DGP_LFSR_ONES   18'h3ffff
`define DGP_X_FB        18'h00081
`define DGP_Y_FB        18'h004a1
`define DGP_X_I         18'h00001
`define DGP_Y_I         18'h00001
`define DGP_X_Q         18'h08050
`define DGP_Y_Q         18'h0ff60
`define DGP_FRAME_LAST  16'h95ff
`define DGP_DIV_OFS     16'h0100
`define DGP_DIV_BIT     9
`define DGP_PM_PRE      8'h03
`define DGP_IVL_SUB     6'h3f
`define DGP_ACC_TOP     49
`define DGP_ACC_BOT     18
`define DGP_HALF        16
`define DGP_FW          37
`define DGP_FIFO_D      16
`endif

// [logic/dgp_pkg.sv]
// Shared types of the channel front end
package dgp_pkg;
   typedef enum logic [1:0] {PM_IDLE, PM_DELAY, PM_INTEG, PM_WAIT} dgp_pm_state_t;
   typedef logic signed [17:0] dgp_smp_t;
endpackage

// [logic/dgp_strm_if.sv]
// Valid/ready stream bundle between the front end and its FIFO
`timescale 1ns/1ps
interface dgp_strm_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [logic/dgp_gain_sat.sv]
// Gain multiply, pilot add and saturation for one rail
`timescale 1ns/1ps
`include "dgp_map.svh"
module dgp_gain_sat (
   input  wire logic signed [17:0] smp_i,
   input  wire logic        [15:0] gain_i,
   input  wire logic signed [16:0] add_i,
   output logic signed      [17:0] y_o
);
   logic signed [34:0] prod;
   logic signed [35:0] sum;
   always_comb
   begin
      prod = smp_i * $signed({1'b0, gain_i});
      sum  = 36'(prod >>> `DGP_GAIN_FRAC) + 36'(add_i);
      // Clip rather than wrap: gains above unity would fold peaks over
      if (sum > `DGP_SAT_HI)
         y_o = 18'sh1ffff;
      else if (sum < `DGP_SAT_LO)
         y_o = 18'sh20000;
      else
         y_o = sum[17:0];
   end
endmodule

// [logic/dgp_fifo.sv]
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dgp_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   dgp_strm_if.snk  wr,
   dgp_strm_if.src  rd
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   n_q, n_d;
   logic          push, pop;

   assign wr.ready = (n_q != D[AW:0]);
   assign rd.valid = (n_q != '0);
   assign rd.data  = mem_q[rp_q];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   always_comb
   begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      n_d  = n_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         wp_q <= '0;
         rp_q <= '0;
         n_q  <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         n_q  <= n_d;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (push)
         mem_q[wp_q] <= wr.data;
   end
endmodule

// [tb/dgp_sink.sv]
// Downstream filter model that takes processed words and can stall
`timescale 1ns/1ps
module dgp_sink (
   input  wire logic        clock_i,
   input  wire logic        valid_i,
   input  wire logic        stall_i,
   input  wire logic [17:0] i_i,
   input  wire logic [17:0] q_i,
   input  wire logic        b_i,
   output logic             ready_o
);
   logic [17:0] qi[$];
   logic [17:0] qq[$];
   logic        qb[$];
   // A busy filter holds ready low for as long as the bench asks
   assign ready_o = !stall_i;
   always @(posedge clock_i)
   begin
      if (valid_i === 1'b1 && ready_o)
      begin
         qi.push_back(i_i);
         qq.push_back(q_i);
         qb.push_back(b_i);
      end
   end
endmodule

// [tb/tb.sv]
// Self-checking bench of the channel front end
`timescale 1ns/1ps
module tb;
   logic        clock_i, resetn_i, in_valid_i, in_sig_b_i, mode_ab_i, pilot_div_i, pm_sync_dis_i, stall;
   logic        in_ready_o, out_valid_o, out_ready_i, pm_ready_o, out_sig_b_o;
   logic [17:0] in_i_i, in_q_i, out_i_o, out_q_o;
   logic [7:0]  sync_i;
   logic [15:0] gain_a_i, gain_b_i, pilot_psc_lo_i, pilot_delay_i, pilot_gain0_i, pilot_gain1_i;
   logic [15:0] pm_res_a_lo_o, pm_res_a_hi_o, pm_res_b_lo_o, pm_res_b_hi_o;
   logic [12:0] pm_integ_i;
   logic [8:0]  pm_interval_i;
   logic [6:0]  pm_delay_i;
   logic [1:0]  pilot_psc_hi_i;
   logic [2:0]  gain_sync_sel_i, pilot_sync_sel_i, pm_sync_sel_i;
   logic [17:0] pi[$], pq[$], mi[$], mq[$];
   logic [31:0] res_a[4], res_b[4];
   int          n_fail = 0;
   int          checked = 0;
   int          takes = 0;
   int          rdy_n = 0;
   int          rdy_at[4];
   int          pos;

   dgp_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
      .in_i_i(in_i_i), .in_q_i(in_q_i), .in_sig_b_i(in_sig_b_i), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .out_i_o(out_i_o), .out_q_o(out_q_o), .out_sig_b_o(out_sig_b_o),
      .mode_ab_i(mode_ab_i),
      .sync_i(sync_i), .gain_a_i(gain_a_i), .gain_b_i(gain_b_i), .gain_sync_sel_i(gain_sync_sel_i),
      .pilot_psc_lo_i(pilot_psc_lo_i), .pilot_psc_hi_i(pilot_psc_hi_i), .pilot_div_i(pilot_div_i),
      .pilot_delay_i(pilot_delay_i), .pilot_gain0_i(pilot_gain0_i), .pilot_gain1_i(pilot_gain1_i),
      .pilot_sync_sel_i(pilot_sync_sel_i), .pm_integ_i(pm_integ_i), .pm_delay_i(pm_delay_i),
      .pm_interval_i(pm_interval_i), .pm_sync_sel_i(pm_sync_sel_i), .pm_sync_dis_i(pm_sync_dis_i),
      .pm_res_a_lo_o(pm_res_a_lo_o), .pm_res_a_hi_o(pm_res_a_hi_o), .pm_res_b_lo_o(pm_res_b_lo_o),
      .pm_res_b_hi_o(pm_res_b_hi_o), .pm_ready_o(pm_ready_o));

   dgp_sink i_sink (.clock_i(clock_i), .valid_i(out_valid_o), .stall_i(stall), .i_i(out_i_o), .q_i(out_q_o),
      .b_i(out_sig_b_o), .ready_o(out_ready_i));

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Result snapshot is taken at the pulse edge, before any later overwrite
   always @(posedge clock_i)
   begin
      if (pm_ready_o === 1'b1 && rdy_n < 4)
      begin
         rdy_at[rdy_n] = takes;
         res_a[rdy_n] = {pm_res_a_hi_o, pm_res_a_lo_o};
         res_b[rdy_n] = {pm_res_b_hi_o, pm_res_b_lo_o};
         rdy_n++;
      end
      if (in_valid_i && in_ready_o === 1'b1)
         takes++;
   end

   task automatic final_report;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Valid stays up between back-to-back words; idle lowers it
   task automatic send(input logic [17:0] i, input logic [17:0] q, input logic b);
      int n;
      n = 0;
      in_valid_i <= 1'b1;
      in_i_i <= i;
      in_q_i <= q;
      in_sig_b_i <= b;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (in_ready_o !== 1'b1 && n < 100);
      if (in_ready_o !== 1'b1)
      begin
         n_fail++;
         $display("unexpected at %0t: input not taken got %h expected %h", $time, in_ready_o, 1'b1);
      end
   endtask

   task automatic idle;
      in_valid_i <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask

   task automatic pop(input logic [17:0] ei, input logic [17:0] eq, input logic eb);
      int n;
      n = 0;
      while (i_sink.qi.size() == 0 && n < 50)
      begin
         @(posedge clock_i);
         n++;
      end
      if (i_sink.qi.size() == 0)
      begin
         n_fail++;
         $display("unexpected at %0t: no output word got %h expected %h", $time, 18'h0, ei);
      end
      else
      begin
         chk(i_sink.qi.pop_front(), ei);
         chk(i_sink.qq.pop_front(), eq);
         chk(i_sink.qb.pop_front(), eb);
      end
   endtask

   task automatic xfer(input logic [17:0] i, input logic [17:0] q, input logic b, input logic [17:0] ei,
                       input logic [17:0] eq);
      send(i, q, b);
      idle();
      pop(ei, eq, b);
   endtask

   task automatic pulse(input int b);
      sync_i <= 8'h01 << b;
      @(posedge clock_i);
      sync_i <= 8'h00;
      @(posedge clock_i);
   endtask

   task automatic clr;
      @(negedge clock_i);
      takes = 0;
      rdy_n = 0;
      i_sink.qi.delete();
      i_sink.qq.delete();
      i_sink.qb.delete();
      @(posedge clock_i);
   endtask

   task automatic prun(input logic div, input logic [15:0] dly, input int n, input logic [17:0] x);
      pilot_div_i <= div;
      pilot_delay_i <= dly;
      pulse(2);
      repeat (n) send(x, x, 1'b0);
      idle();
      pi = i_sink.qi;
      pq = i_sink.qq;
      i_sink.qi.delete();
      i_sink.qq.delete();
      i_sink.qb.delete();
   endtask

   initial
   begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      final_report();
   end

   initial
   begin
      {resetn_i, in_valid_i, in_sig_b_i, mode_ab_i, pilot_div_i, pm_sync_dis_i, stall} = 7'h00;
      {in_i_i, in_q_i, sync_i, gain_a_i, gain_b_i, pilot_delay_i, pilot_gain0_i, pilot_gain1_i} = 0;
      {pm_integ_i, pm_delay_i, pm_interval_i} = 0;
      pilot_psc_lo_i = 16'h1234;
      pilot_psc_hi_i = 2'h1;
      gain_sync_sel_i = 3'h1;
      pilot_sync_sel_i = 3'h2;
      pm_sync_sel_i = 3'h3;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(negedge clock_i);
      chk({in_ready_o, out_valid_o, pm_ready_o}, 3'h4);
      chk({pm_res_a_hi_o, pm_res_a_lo_o}, 32'h0);
      @(posedge clock_i);
      gain_a_i <= 16'h4000;
      gain_b_i <= 16'h1000;
      xfer(18'h00064, 18'h3ff9c, 1'b0, 18'h0, 18'h0);
      pulse(1);
      xfer(18'h00064, 18'h3ff9c, 1'b0, 18'h000c8, 18'h3ff38);
      gain_a_i <= 16'hffff;
      pulse(5);
      xfer(18'h00064, 18'h3ff9c, 1'b0, 18'h000c8, 18'h3ff38);
      pulse(1);
      xfer(18'h1ffff, 18'h20000, 1'b0, 18'h1ffff, 18'h20000);
      mode_ab_i <= 1'b1;
      gain_a_i <= 16'h4000;
      pulse(1);
      xfer(18'h00064, 18'h00064, 1'b0, 18'h000c8, 18'h000c8);
      xfer(18'h00064, 18'h00064, 1'b1, 18'h00032, 18'h00032);
      mode_ab_i <= 1'b0;
      gain_a_i <= 16'h2000;
      gain_b_i <= 16'h2000;
      pulse(1);
      stall <= 1'b1;
      for (int k = 0; k < 16; k++)
         send(18'(k), 18'(k), 1'b0);
      idle();
      @(negedge clock_i);
      chk({in_ready_o, out_valid_o}, 2'h1);
      @(posedge clock_i);
      stall <= 1'b0;
      for (int k = 0; k < 16; k++)
         pop(18'(k), 18'(k), 1'b0);
      // Equal pilot gains in single mode only
      pilot_gain0_i <= 16'h0064;
      pilot_gain1_i <= 16'h0064;
      prun(1'b0, 16'h0000, 260, 18'h0);
      mi = pi;
      mq = pq;
      pos = 0;
      for (int k = 0; k < 260; k++)
      begin
         chk(mi[k] == 18'h00064 || mi[k] == 18'h3ff9c, 1'b1);
         chk(mq[k] == 18'h00064 || mq[k] == 18'h3ff9c, 1'b1);
         pos += (mi[k] == 18'h00064);
      end
      chk(pos > 0 && pos < 260, 1'b1);
      prun(1'b0, 16'h0003, 263, 18'h00010);
      for (int k = 0; k < 263; k++)
         chk(pi[k], k < 3 ? 18'h00010 : mi[k-3] + 18'h00010);
      prun(1'b1, 16'h0000, 260, 18'h0);
      for (int k = 0; k < 260; k++)
      begin
         chk(pi[k], k < 256 ? mi[k] : 18'(-mi[k]));
         chk(pq[k], k < 256 ? mq[k] : 18'(-mq[k]));
      end
      pilot_gain0_i <= 16'h0000;
      pilot_gain1_i <= 16'h0000;
      pm_integ_i <= 13'h0001;
      pm_delay_i <= 7'h02;
      pm_interval_i <= 9'h000;
      clr();
      pulse(3);
      for (int k = 0; k < 80; k++)
         send(k < 10 ? 18'h00400 : 18'h00800, k < 10 ? 18'h00400 : 18'h00000, 1'b0);
      idle();
      chk(rdy_n, 2);
      chk(rdy_at[0], 10);
      chk(res_a[0], 32'h28);
      chk(rdy_at[1], 74);
      chk(res_a[1], 32'h50);
      pm_integ_i <= 13'h0000;
      pm_delay_i <= 7'h00;
      pulse(3);
      repeat (2) send(18'h00400, 18'h00400, 1'b0);
      idle();
      clr();
      pulse(3);
      pm_sync_dis_i <= 1'b1;
      repeat (2) send(18'h00400, 18'h00400, 1'b0);
      idle();
      pulse(3);
      repeat (2) send(18'h00400, 18'h00400, 1'b0);
      idle();
      chk(rdy_n, 1);
      chk(rdy_at[0], 4);
      chk(res_a[0], 32'h8);
      pm_sync_dis_i <= 1'b0;
      mode_ab_i <= 1'b1;
      pm_interval_i <= 9'h002;
      clr();
      pulse(3);
      for (int k = 0; k < 4; k++)
      begin
         send(18'h00400, 18'h00400, 1'b0);
         send(18'h00800, 18'h00000, 1'b1);
      end
      idle();
      chk(rdy_at[0], 8);
      chk(res_a[0], 32'h4);
      chk(res_b[0], 32'h10);
      final_report();
   end
endmodule
